// File: hdl/sleep_sub_pkg.sv
package sleep_sub_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_WORKING_REGISTER   = 8'h04;
  localparam logic [7:0] OFF_BSR    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_FADDR  = 8'h10;
  localparam logic [7:0] OFF_FDATA  = 8'h14;

  // instruction encodings and operand fields
  localparam logic [15:0] OPC_SLEEP  = 16'h0003;
  localparam logic [5:0]  OPC_SUBTRACT_WITH_BORROW_OP = 6'h15;
  localparam int          OPC_MSB    = 15;
  localparam int          OPC_LSB    = 10;
  localparam int          D_BIT      = 9;
  localparam int          A_BIT      = 8;
  localparam int          INSTR_W    = 16;

  // status layout; the low five bits are the alu flags
  localparam int ST_C     = 0;
  localparam int ST_DC    = 1;
  localparam int ST_Z     = 2;
  localparam int ST_OV    = 3;
  localparam int ST_N     = 4;
  localparam int ST_PD    = 5;
  localparam int ST_TO    = 6;
  localparam int ST_SLEEP = 7;
  localparam int ST_BUSY  = 8;
  localparam int FLAG_W   = 5;

  localparam logic PD_RESET = 1'b1;
  localparam logic TO_RESET = 1'b1;

  // data memory organisation
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam int         BANK_BYTES   = 256;
  localparam int         BSR_W        = 4;
  localparam int         MAX_BANKS    = 16;
  localparam int         DATA_W       = 8;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4,
    PH_SLEEP
  } phase_e;

endpackage : sleep_sub_pkg

// File: hdl/borrow_subtract.sv
`timescale 1ns/1ps
module borrow_subtract
  import sleep_sub_pkg::*;
(
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  input  wire logic              carry_in,
  output logic      [DATA_W-1:0] diff,
  output logic      [FLAG_W-1:0] flags
);

  logic [DATA_W:0] sum_full;
  logic [4:0]      sum_low;

  // w - f - !c computed as w + ~f + c, so carry out means no borrow
  always_comb
  begin
    sum_full = {1'b0, minuend} + {1'b0, ~subtrahend}
             + {{DATA_W{1'b0}}, carry_in};
    sum_low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
             + {4'h0, carry_in};
    diff            = sum_full[DATA_W-1:0];
    flags           = '0;
    flags[ST_C]     = sum_full[DATA_W];
    flags[ST_DC]    = sum_low[4];
    flags[ST_Z]     = (sum_full[DATA_W-1:0] == '0);
    flags[ST_N]     = sum_full[DATA_W-1];
    flags[ST_OV]    = (minuend[DATA_W-1] ^ subtrahend[DATA_W-1])
                    & (sum_full[DATA_W-1] ^ minuend[DATA_W-1]);
  end

endmodule : borrow_subtract

// File: hdl/sleep_sub_core.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module sleep_sub_core
  import sleep_sub_pkg::*;
#(
  parameter int NUM_BANKS = 2
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        WDT_WAKE,
  input  wire logic        EXT_WAKE,
  output logic             WDT_CLEAR,
  output logic             OSC_STOP,
  output logic             POWER_DOWN_FLAG,
  output logic             TIMEOUT_FLAG
);

  localparam int BW        = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
  localparam int IW        = BW + DATA_W;
  localparam int MEM_BYTES = NUM_BANKS * BANK_BYTES;

  generate
    if (NUM_BANKS < 2 || NUM_BANKS > MAX_BANKS ||
        (NUM_BANKS & (NUM_BANKS - 1)) != 0)
    begin : g_bad_banks
      $error("NUM_BANKS must be a power of two from 2 to 16");
    end
  endgenerate

  typedef struct packed {
    phase_e                           phase;
    logic [INSTR_W-1:0]               instr;
    logic [DATA_W-1:0]                working_register;
    logic [BSR_W-1:0]                 bank_select_register;
    logic [FLAG_W-1:0]                flags;
    logic                             pd;
    logic                             to;
    logic [IW-1:0]                    faddr;
    logic [IW-1:0]                    idx;
    logic [DATA_W-1:0]                operand;
    logic [DATA_W-1:0]                result;
    logic [FLAG_W-1:0]                res_flags;
    logic                             wdt_clr;
    logic                             osc_stop;
    logic                             pready;
    logic                             pslverr;
    logic [31:0]                      prdata;
    logic [1:0]                       wdt_sync;
    logic [1:0]                       wake_sync;
    logic [MEM_BYTES-1:0][DATA_W-1:0] mem;
  } state_s;

  state_s            s_q;
  state_s            s_d;
  logic [DATA_W-1:0] alu_diff;
  logic [FLAG_W-1:0] alu_flags;
  logic              is_sub;
  logic              is_sleep;
  logic              apb_wr;

  // file address resolution: access bank splits low ram and top bank
  function automatic logic [IW-1:0] map_index(
    input logic [BSR_W-1:0]  bank_select_register,
    input logic              acc,
    input logic [DATA_W-1:0] f
  );
    logic [BW-1:0] bank;
    bank = '0;
    if (acc)
      bank = bank_select_register[BW-1:0];
    else if (f >= ACCESS_SPLIT)
      bank = BW'(NUM_BANKS - 1);
    else
      bank = '0;
    return {bank, f};
  endfunction : map_index

  function automatic logic reg_mapped(input logic [7:0] addr);
    return (addr == OFF_INSTR) || (addr == OFF_WORKING_REGISTER) ||
           (addr == OFF_BSR) || (addr == OFF_STATUS) ||
           (addr == OFF_FADDR) || (addr == OFF_FDATA);
  endfunction : reg_mapped

  assign is_sub   = (s_q.instr[OPC_MSB:OPC_LSB] == OPC_SUBTRACT_WITH_BORROW_OP);
  assign is_sleep = (s_q.instr == OPC_SLEEP);
  assign apb_wr   = PSEL & PENABLE & s_q.pready & PWRITE;

  borrow_subtract u_alu (
    .minuend    (s_q.working_register),
    .subtrahend (s_q.operand),
    .carry_in   (s_q.flags[ST_C]),
    .diff       (alu_diff),
    .flags      (alu_flags)
  );

  always_comb
  begin
    s_d           = s_q;
    s_d.wdt_clr   = 1'b0;
    s_d.wdt_sync  = {s_q.wdt_sync[0], WDT_WAKE};
    s_d.wake_sync = {s_q.wake_sync[0], EXT_WAKE};

    // apb: answer in the first access cycle, read data taken at setup, write data in the access cycle
    if (PSEL && !PENABLE)
    begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !reg_mapped(PADDR);
      s_d.prdata  = '0;
      if (PADDR == OFF_INSTR)
        s_d.prdata[INSTR_W-1:0] = s_q.instr;
      else if (PADDR == OFF_WORKING_REGISTER)
        s_d.prdata[DATA_W-1:0] = s_q.working_register;
      else if (PADDR == OFF_BSR)
        s_d.prdata[BSR_W-1:0] = s_q.bank_select_register;
      else if (PADDR == OFF_STATUS)
      begin
        s_d.prdata[FLAG_W-1:0] = s_q.flags;
        s_d.prdata[ST_PD]      = s_q.pd;
        s_d.prdata[ST_TO]      = s_q.to;
        s_d.prdata[ST_SLEEP]   = (s_q.phase == PH_SLEEP);
        s_d.prdata[ST_BUSY]    = (s_q.phase != PH_IDLE) &&
                                 (s_q.phase != PH_SLEEP);
      end
      else if (PADDR == OFF_FADDR)
        s_d.prdata[IW-1:0] = s_q.faddr;
      else if (PADDR == OFF_FDATA)
        s_d.prdata[DATA_W-1:0] = s_q.mem[s_q.faddr];
    end
    else if (PSEL && PENABLE && s_q.pready)
    begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end

    // software writes; hardware updates below win on a collision
    if (apb_wr)
    begin
      if (PADDR == OFF_INSTR)
      begin
        // a launch while busy or asleep is dropped
        if (s_q.phase == PH_IDLE)
        begin
          s_d.instr = PWDATA[INSTR_W-1:0];
          s_d.phase = PH_Q1;
        end
      end
      else if (PADDR == OFF_WORKING_REGISTER)
        s_d.working_register = PWDATA[DATA_W-1:0];
      else if (PADDR == OFF_BSR)
        s_d.bank_select_register = PWDATA[BSR_W-1:0];
      else if (PADDR == OFF_STATUS)
        s_d.flags = PWDATA[FLAG_W-1:0];
      else if (PADDR == OFF_FADDR)
        s_d.faddr = PWDATA[IW-1:0];
      else if (PADDR == OFF_FDATA)
        s_d.mem[s_q.faddr] = PWDATA[DATA_W-1:0];
    end

    // four-phase instruction cycle
    case (s_q.phase)
      PH_Q1:
      begin
        s_d.idx   = map_index(s_q.bank_select_register, s_q.instr[A_BIT],
                              s_q.instr[DATA_W-1:0]);
        s_d.phase = PH_Q2;
      end
      PH_Q2:
      begin
        if (is_sub)
          s_d.operand = s_q.mem[s_q.idx];
        s_d.phase = PH_Q3;
      end
      PH_Q3:
      begin
        s_d.result    = alu_diff;
        s_d.res_flags = alu_flags;
        s_d.phase     = PH_Q4;
      end
      PH_Q4:
      begin
        s_d.phase = PH_IDLE;
        if (is_sleep)
        begin
          s_d.pd       = 1'b0;
          s_d.to       = 1'b1;
          s_d.wdt_clr  = 1'b1;
          s_d.osc_stop = 1'b1;
          s_d.phase    = PH_SLEEP;
        end
        else if (is_sub)
        begin
          s_d.flags = s_q.res_flags;
          if (s_q.instr[D_BIT])
            s_d.mem[s_q.idx] = s_q.result;
          else
            s_d.working_register = s_q.result;
        end
      end
      PH_SLEEP:
      begin
        // wake is level sensitive; watchdog wins if both are high
        if (s_q.wdt_sync[1])
        begin
          s_d.to       = 1'b0;
          s_d.osc_stop = 1'b0;
          s_d.phase    = PH_IDLE;
        end
        else if (s_q.wake_sync[1])
        begin
          s_d.osc_stop = 1'b0;
          s_d.phase    = PH_IDLE;
        end
      end
      default: s_d.phase = s_d.phase;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      s_q    <= '0;
      s_q.pd <= PD_RESET;
      s_q.to <= TO_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign PRDATA          = s_q.prdata;
  assign PREADY          = s_q.pready;
  assign PSLVERR         = s_q.pslverr;
  assign WDT_CLEAR       = s_q.wdt_clr;
  assign OSC_STOP        = s_q.osc_stop;
  assign POWER_DOWN_FLAG = s_q.pd;
  assign TIMEOUT_FLAG    = s_q.to;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  logic sleep_commit;
  logic sub_commit;
  assign sleep_commit = (s_q.phase == PH_Q4) && is_sleep;
  assign sub_commit   = (s_q.phase == PH_Q4) && is_sub && !apb_wr;

  sequence s_launch;
    (s_q.phase == PH_IDLE) && apb_wr && (PADDR == OFF_INSTR);
  endsequence

  sequence s_four_phase;
    (s_q.phase == PH_Q1) ##1 (s_q.phase == PH_Q2) ##1
    (s_q.phase == PH_Q3) ##1 (s_q.phase == PH_Q4);
  endsequence

  sequence s_sleep_entry;
    OSC_STOP && WDT_CLEAR && (s_q.phase == PH_SLEEP) ##1 !WDT_CLEAR;
  endsequence

  property p_one_cycle;
    s_launch |=> s_four_phase ##1
                 ((s_q.phase == PH_IDLE) || (s_q.phase == PH_SLEEP));
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("instruction did not take four phases");
  property p_pd_clear;
    sleep_commit |=> !POWER_DOWN_FLAG;
  endproperty
  a_pd_clear: assert property (p_pd_clear)
    else $error("power-down flag not cleared by sleep");
  property p_to_set;
    sleep_commit |=> TIMEOUT_FLAG;
  endproperty
  a_to_set: assert property (p_to_set)
    else $error("timeout flag not set by sleep");
  property p_wdt_clear;
    sleep_commit |=> s_sleep_entry;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog clear pulse wrong on sleep");
  property p_sleep_hold;
    (s_q.phase == PH_SLEEP) && !s_q.wdt_sync[1] && !s_q.wake_sync[1]
      |=> (s_q.phase == PH_SLEEP) && OSC_STOP;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("left sleep without a wake source");
  property p_wdt_wake;
    (s_q.phase == PH_SLEEP) && s_q.wdt_sync[1]
      |=> !TIMEOUT_FLAG && !OSC_STOP && (s_q.phase == PH_IDLE);
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog wake did not clear timeout flag");
  property p_arith;
    (s_q.phase == PH_Q3) && is_sub
      |=> s_q.result == $past(s_q.working_register - s_q.operand
                              - {7'h00, ~s_q.flags[ST_C]});
  endproperty
  a_arith: assert property (p_arith)
    else $error("subtract with borrow result wrong");
  property p_dest_w;
    sub_commit && !s_q.instr[D_BIT]
      |=> (s_q.working_register == $past(s_q.result)) &&
          (s_q.mem[$past(s_q.idx)] == $past(s_q.mem[s_q.idx]));
  endproperty
  a_dest_w: assert property (p_dest_w)
    else $error("direction zero did not target working register");
  property p_dest_f;
    sub_commit && s_q.instr[D_BIT]
      |=> s_q.mem[$past(s_q.idx)] == $past(s_q.result);
  endproperty
  a_dest_f: assert property (p_dest_f)
    else $error("direction one did not write file register");
  property p_access_bank;
    (s_q.phase == PH_Q1) && !s_q.instr[A_BIT]
      |=> s_q.idx == {(($past(s_q.instr[DATA_W-1:0]) >= ACCESS_SPLIT)
                       ? BW'(NUM_BANKS - 1) : BW'(0)),
                      $past(s_q.instr[DATA_W-1:0])};
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access bank resolution wrong");
  property p_bsr_bank;
    (s_q.phase == PH_Q1) && s_q.instr[A_BIT]
      |=> (s_q.idx[IW-1:DATA_W] == $past(s_q.bank_select_register[BW-1:0])) &&
          (s_q.idx[DATA_W-1:0] == $past(s_q.instr[DATA_W-1:0]));
  endproperty
  a_bsr_bank: assert property (p_bsr_bank)
    else $error("bank select resolution wrong");
  property p_flags;
    (s_q.phase == PH_Q3) && is_sub
      |-> (alu_flags[ST_C] == ({1'b0, s_q.working_register} >=
           ({1'b0, s_q.operand} + {8'h00, ~s_q.flags[ST_C]}))) &&
          (alu_flags[ST_Z] == (alu_diff == '0)) &&
          (alu_flags[ST_N] == alu_diff[DATA_W-1]);
  endproperty
  a_flags: assert property (p_flags)
    else $error("subtract flags wrong");
  property p_flags_commit;
    sub_commit |=> s_q.flags == $past(s_q.res_flags);
  endproperty
  a_flags_commit: assert property (p_flags_commit)
    else $error("flags not written at end of cycle");

endmodule : sleep_sub_core

// File: bench/sleep_and_borrow_subtract_tb_top.sv
`timescale 1ns/1ps
module sleep_and_borrow_subtract_tb_top
  import sleep_sub_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        wdt_wake = 1'b0;
  logic        ext_wake = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        WDT_CLEAR;
  logic        OSC_STOP;
  logic        POWER_DOWN_FLAG;
  logic        TIMEOUT_FLAG;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          seed        = 64798;
  int          cycles      = 0;
  int          pulses      = 0;
  logic [31:0] rd;
  logic        err;

  always #2.5 clk_sys = ~clk_sys;

  sleep_sub_core #(.NUM_BANKS(2)) DUT (
    .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .WDT_WAKE(wdt_wake),
    .EXT_WAKE(ext_wake), .WDT_CLEAR(WDT_CLEAR), .OSC_STOP(OSC_STOP),
    .POWER_DOWN_FLAG(POWER_DOWN_FLAG), .TIMEOUT_FLAG(TIMEOUT_FLAG)
  );

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // a hang in a handshake ends here instead of running forever
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  // counted at the falling edge, clear of the launching edge
  always @(negedge clk_sys)
    if (WDT_CLEAR === 1'b1)
      pulses <= pulses + 1;

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // an idle cycle before each setup keeps psel from two drives in one step
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    psel    <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    // pready is sampled at the rising edge; the bench timeout ends a hang
    do
      @(posedge clk_sys);
    while (PREADY !== 1'b1);
    rd      = PRDATA;
    err     = PSLVERR;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run(input logic [15:0] ins);
    apb(1'b1, OFF_INSTR, {16'h0, ins});
    apb(1'b0, OFF_STATUS, 32'h0);
    check("busy early", 32'h1, rd[ST_BUSY]);
    @(posedge clk_sys);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("busy done", 32'h0, rd[ST_BUSY]);
  endtask : run

  task automatic wake(input logic by_wdt);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (by_wdt)
      wdt_wake <= 1'b1;
    else
      ext_wake <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (OSC_STOP !== 1'b0 && n < 20);
    check("osc after wake", 32'h0, OSC_STOP);
    // wakes are levels, so they must drop before the next sleep
    @(posedge clk_sys);
    wdt_wake <= 1'b0;
    ext_wake <= 1'b0;
  endtask : wake

  // returns {n, ov, z, dc, c, result}
  function automatic logic [12:0] sub_model(input logic [7:0] w,
                                            input logic [7:0] f,
                                            input logic c);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, w} + {1'b0, ~f} + {8'h0, c};
    h = {1'b0, w[3:0]} + {1'b0, ~f[3:0]} + {4'h0, c};
    return {s[7], (w[7] != f[7]) && (s[7] != w[7]), s[7:0] == 8'h0,
            h[4], s[8], s[7:0]};
  endfunction : sub_model

  logic [7:0]  w;
  logic [7:0]  v;
  logic [7:0]  fa;
  logic [3:0]  bank_select_register;
  logic        c;
  logic        d;
  logic        a;
  logic [12:0] e;
  logic [31:0] idx;
  int          p0;

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("pd reset", 32'h1, POWER_DOWN_FLAG);
    check("to reset", 32'h1, TIMEOUT_FLAG);
    for (int i = 0; i < 40; i++)
    begin
      w   = 8'($random(seed));
      v   = 8'($random(seed));
      c   = 1'($random(seed));
      d   = 1'($random(seed));
      a   = 1'($random(seed));
      bank_select_register = 4'($random(seed));
      fa  = 8'($random(seed));
      // worked corners: negative, positive, zero with borrow
      if (i == 0)
        {w, v, c, d, a, fa} = {8'h02, 8'h03, 3'b111, 8'h85};
      if (i == 1)
        {w, v, c, d, a, fa} = {8'h05, 8'h02, 3'b100, 8'h10};
      if (i == 2)
        {w, v, c, d, a, fa} = {8'h02, 8'h01, 3'b010, 8'hF0};
      idx = {23'h0, a ? bank_select_register[0] : fa[7], fa};
      apb(1'b1, OFF_FADDR, idx);
      apb(1'b1, OFF_FDATA, {24'h0, v});
      apb(1'b1, OFF_WORKING_REGISTER, {24'h0, w});
      apb(1'b1, OFF_BSR, {28'h0, bank_select_register});
      apb(1'b1, OFF_STATUS, {31'h0, c});
      run({OPC_SUBTRACT_WITH_BORROW_OP, d, a, fa});
      e = sub_model(w, v, c);
      apb(1'b0, OFF_WORKING_REGISTER, 32'h0);
      check("working_register", {24'h0, d ? w : e[7:0]}, rd);
      check("mapped err", 32'h0, err);
      apb(1'b0, OFF_FDATA, 32'h0);
      check("file", {24'h0, d ? e[7:0] : v}, rd);
      apb(1'b0, OFF_STATUS, 32'h0);
      check("flags", {27'h0, e[12:8]}, {27'h0, rd[4:0]});
    end
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped err", 32'h1, err);
    apb(1'b1, OFF_WORKING_REGISTER, 32'h11);
    for (int k = 0; k < 2; k++)
    begin
      p0 = pulses;
      run(OPC_SLEEP);
      check("asleep", 32'h1, rd[ST_SLEEP]);
      check("pd sleep", 32'h0, POWER_DOWN_FLAG);
      check("to sleep", 32'h1, TIMEOUT_FLAG);
      check("osc stop", 32'h1, OSC_STOP);
      check("wdt clears", 32'h1, pulses - p0);
      // a launch while asleep must be dropped
      apb(1'b1, OFF_INSTR, {16'h0, OPC_SUBTRACT_WITH_BORROW_OP, 2'b00, 8'h00});
      wake(k[0]);
      check("to wake", {31'h0, k == 0}, TIMEOUT_FLAG);
      apb(1'b0, OFF_WORKING_REGISTER, 32'h0);
      check("working_register kept", 32'h11, rd);
    end
    run(OPC_SLEEP);
    check("to resleep", 32'h1, TIMEOUT_FLAG);
    wake(1'b0);
    report_and_stop();
  end
endmodule : sleep_and_borrow_subtract_tb_top
